// *** rtl/dspm_ctrl.sv ***
// Serial port, control register and monitor multiplexer of a 32-channel DAC
//
// Operation
// [R1] Host sets input bit before falling edge
// [R2] Host holds frame sync low per word
// [R3] Output on rising edge, capture falling
// [R4] Words travel most significant bit first
// [R5] Host supplies shift clock; device only follows
// [R6] Byte hosts send eight edges per byte
// [R7] Byte hosts may need three bytes
// [R8] Word hosts use internal clock, 16-bit; the port here acts only on 24-bit words
// [R9] Parallel host decodes select and load
// [R10] External reference selected after power-up
// [R11] Control bits pick reference level, source
// [R12] Power-on reset 10 ms loads calibration
// [R13] Slow supply ramp needs host reset
// [R14] Monitor mux routes selected channel out
// [R15] No routing until monitor enable set
// [R16] Monitor address 63 gives high impedance
// [R17] Five-bit address selects 32 channels
// [R18] After reset monitor disabled, output off
`timescale 1ns/100ps
`include "dspm_consts.svh"
module dspm_ctrl #(
    parameter int NCH     = 32,
    parameter int POR_CYC = `DSPM_POR_MS * `DSPM_CLK_KHZ
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    input  wire logic                  i_sclk,
    input  wire logic                  i_sync_n,
    input  wire logic                  i_din,
    output logic                       o_dout,
    output logic                       o_dout_oe_n,
    input  wire logic                  i_par_cs_n,
    input  wire logic                  i_par_wr_n,
    input  wire logic [`DSPM_CH_W-1:0] i_channel_addr,
    input  wire logic [11:0]           i_par_data,
    input  wire logic                  i_load_strobe_n,
    output logic                       o_init_busy,
    output logic                       o_cal_load,
    output logic                       o_ref_level_sel,
    output logic                       o_internal_ref_sel,
    output logic                       o_monitor_en,
    output logic [`DSPM_CH_W-1:0]      o_monitor_out_sel,
    output logic                       o_monitor_out_oe_n,
    output logic                       o_load_pulse
);
    localparam int CW = $clog2(POR_CYC + 1);
    initial
    begin
        if (NCH != 32 || POR_CYC < 1)
            $error("dspm_ctrl: unsupported parameters");
    end

    // ------------------------------------------------------------
    // Link domain: shift register on the host clock
    // ------------------------------------------------------------
    logic [`DSPM_WORD_W-1:0] shreg;
    logic [`DSPM_WORD_W-1:0] next_shreg;
    logic [4:0]              bitcnt;
    logic [4:0]              next_bitcnt;
    logic [`DSPM_WORD_W-1:0] word;
    logic [`DSPM_WORD_W-1:0] next_word;
    logic                    wtog;
    logic                    next_wtog;
    logic [11:0]             rdback;
    logic [4:0]              rcnt;
    logic [4:0]              next_rcnt;

    always_comb
    begin
        next_shreg  = shreg;
        next_bitcnt = bitcnt;
        next_word   = word;
        next_wtog   = wtog;
        if (!i_sync_n)
        begin
            next_shreg  = {shreg[`DSPM_WORD_W-2:0], i_din}; // see [R4]
            next_bitcnt = bitcnt + 5'h01;
            if (bitcnt == 5'(`DSPM_WORD_W - 1))
            begin
                next_word   = {shreg[`DSPM_WORD_W-2:0], i_din};
                next_wtog   = ~wtog;
                next_bitcnt = 5'h00;
            end
        end
        else
            next_bitcnt = 5'h00;
    end

    // Capture on falling edge
    always_ff @(negedge i_sclk or negedge i_rst_n) // see [R3]
    begin
        if (!i_rst_n)
        begin
            shreg  <= '0;
            word   <= '0;
            wtog   <= 1'b0;
        end
        else
        begin
            shreg  <= next_shreg;
            word   <= next_word;
            wtog   <= next_wtog;
        end
    end

    // Host clock stops between frames: sync high clears the count at once
    always_ff @(negedge i_sclk or negedge i_rst_n or posedge i_sync_n)
    begin
        if (!i_rst_n || i_sync_n)
            bitcnt <= 5'h00;
        else
            bitcnt <= next_bitcnt;
    end

    // Rising edges within the frame pick the next readback bit
    always_comb
    begin
        next_rcnt = (rcnt == 5'h1F) ? rcnt : rcnt + 5'h01;
    end

    always_ff @(posedge i_sclk or negedge i_rst_n or posedge i_sync_n)
    begin
        if (!i_rst_n || i_sync_n)
            rcnt <= 5'h00;
        else
            rcnt <= next_rcnt; // see [R3]
    end

    // First bit stands from frame start, as no rising edge precedes it;
    // readback word is quasi-static control state
    assign o_dout      = (rcnt < 5'h0C) ? rdback[4'hB - rcnt[3:0]]
                                        : 1'b0; // see [R4]
    assign o_dout_oe_n = i_sync_n;

    // ------------------------------------------------------------
    // System domain: crossing, power-on timer, control register
    // ------------------------------------------------------------
    logic       tog_s;
    logic       tog_d;
    logic [2:0] par_s;
    logic       par_d;
    logic       ld_d;
    dspm_sync #(.W(1)) u_tog (
        .i_clk   (i_clk_sys),
        .i_rst_n (i_rst_n),
        .i_en    (i_ce),
        .i_d     (wtog),
        .o_q     (tog_s)
    );
    dspm_sync #(.W(3)) u_par (
        .i_clk   (i_clk_sys),
        .i_rst_n (i_rst_n),
        .i_en    (i_ce),
        .i_d     ({i_par_cs_n, i_par_wr_n, i_load_strobe_n}),
        .o_q     (par_s)
    );

    dspm_pkg::dspm_state_t   st;
    dspm_pkg::dspm_state_t   next_st;
    logic [CW-1:0]           por_cnt;
    logic [CW-1:0]           next_por_cnt;
    logic [11:0]             cr;
    logic [11:0]             next_cr;
    logic [`DSPM_MON_W-1:0]  mon;
    logic [`DSPM_MON_W-1:0]  next_mon;
    logic                    ldp;
    logic                    next_ldp;
    logic                    sw;
    logic                    pw;
    logic [`DSPM_CH_W-1:0]   waddr;
    logic [11:0]             wdata;

    // Serial word arrives when toggle changes; parallel on write rise
    assign sw    = tog_s != tog_d;
    assign pw    = par_s[1] && !par_d && !par_s[2]; // see [R9]
    assign waddr = sw ? word[`DSPM_ADDR_LO+4:`DSPM_ADDR_LO] : i_channel_addr;
    assign wdata = sw ? word[`DSPM_DATA_HI:`DSPM_DATA_LO] : i_par_data;
    assign rdback = cr; // Only the control register reads back

    always_comb
    begin
        next_st      = st;
        next_por_cnt = por_cnt;
        next_cr      = cr;
        next_mon     = mon;
        next_ldp     = !par_s[0] && ld_d;
        case (st)
            dspm_pkg::DSPM_INIT:
            begin
                next_por_cnt = por_cnt + CW'(1); // see [R12]
                if (por_cnt == CW'(POR_CYC - 1))
                    next_st = dspm_pkg::DSPM_RUN;
            end
            dspm_pkg::DSPM_RUN:
            begin
                // Writes land only after initialisation, as calibration loads
                if ((sw && !word[`DSPM_RD_BIT]) || pw)
                begin
                    if (waddr == `DSPM_CTRL_ADDR)
                        next_cr = wdata; // see [R11]
                    else if (sw && word[`DSPM_ADDR_HI:`DSPM_ADDR_LO]
                             == `DSPM_MON_CMD)
                        next_mon = wdata[`DSPM_MON_W-1:0]; // see [R14]
                end
            end
            default: next_st = dspm_pkg::DSPM_INIT;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st      <= dspm_pkg::DSPM_INIT;
            por_cnt <= '0;
            cr      <= `DSPM_CR_RST; // see [R10] [R18]
            mon     <= `DSPM_MON_OFF; // see [R18]
            tog_d   <= 1'b0;
            par_d   <= 1'b1;
            ld_d    <= 1'b1;
            ldp     <= 1'b0;
        end
        else if (i_ce)
        begin
            st      <= next_st;
            por_cnt <= next_por_cnt;
            cr      <= next_cr;
            mon     <= next_mon;
            tog_d   <= tog_s;
            par_d   <= par_s[1];
            ld_d    <= par_s[0];
            ldp     <= next_ldp;
        end
    end

    assign o_init_busy        = st == dspm_pkg::DSPM_INIT;
    assign o_cal_load         = o_init_busy;
    assign o_ref_level_sel    = cr[`DSPM_CR_REFLVL]; // see [R11]
    assign o_internal_ref_sel = cr[`DSPM_CR_INTREF]; // see [R10]
    assign o_monitor_en       = cr[`DSPM_CR_MONEN];
    assign o_monitor_out_sel  = mon[`DSPM_CH_W-1:0]; // see [R17]
    // Channel codes above 31 other than 63 also stay off
    assign o_monitor_out_oe_n = !cr[`DSPM_CR_MONEN] // see [R15]
                                || mon[`DSPM_MON_W-1]; // see [R16]
    assign o_load_pulse       = ldp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_mon_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_monitor_en |-> o_monitor_out_oe_n) // see [R15]
        else $error("monitor driven while disabled");
    a_mon_off63: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        mon == `DSPM_MON_OFF |-> o_monitor_out_oe_n) // see [R16]
        else $error("monitor driven at code 63");
    a_init_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_init_busy |-> !o_internal_ref_sel) // see [R10]
        else $error("internal reference on during init");
    a_init_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $fell(o_init_busy) |-> por_cnt == CW'(POR_CYC)) // see [R12]
        else $error("power-on interval wrong");
    a_cr_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !sw && !pw && i_ce |=> $stable(cr)) // see [R11]
        else $error("control register changed without write");
    a_mon_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_monitor_en && !mon[`DSPM_MON_W-1] |-> !o_monitor_out_oe_n)
        // see [R14]
        else $error("enabled monitor not routed");
    a_sel_width: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_monitor_out_oe_n |-> o_monitor_out_sel == mon[4:0]) // see [R17]
        else $error("monitor select mismatch");
    a_dout_oe: assert property (@(posedge i_sclk) disable iff (!i_rst_n)
        i_sync_n |-> o_dout_oe_n) // see [R3]
        else $error("readback driven outside frame");
endmodule

// *** rtl/dspm_consts.svh ***
// Constants of the serial port and monitor control block
`ifndef DSPM_CONSTS_SVH
`define DSPM_CONSTS_SVH
`define DSPM_WORD_W        24
`define DSPM_CH_W          5
`define DSPM_MON_W         6
`define DSPM_MON_OFF       6'h3F
`define DSPM_CTRL_ADDR     5'h0C
`define DSPM_RD_BIT        23
`define DSPM_REG_HI        21
`define DSPM_REG_LO        20
`define DSPM_ADDR_HI       19
`define DSPM_ADDR_LO       14
`define DSPM_DATA_HI       11
`define DSPM_DATA_LO       0
`define DSPM_MON_CMD       6'h3E
`define DSPM_CR_REFLVL     10
`define DSPM_CR_INTREF     8
`define DSPM_CR_MONEN      7
`define DSPM_CR_RST        12'h000
`define DSPM_POR_MS        10
`define DSPM_CLK_KHZ       20000
`endif

// *** rtl/dspm_pkg.sv ***
// Types of the serial port and monitor control block
package dspm_pkg;
    typedef enum logic [1:0] {DSPM_INIT, DSPM_RUN} dspm_state_t;
endpackage

// *** rtl/dspm_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module dspm_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_meta = i_en ? i_d : meta;
        next_q    = i_en ? meta : o_q;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta <= '0;
            o_q  <= '0;
        end
        else
        begin
            meta <= next_meta;
            o_q  <= next_q;
        end
    end
endmodule

// *** verification/dspm_host_model.sv ***
// Serial host model driving the link side of the control block
`timescale 1ns/100ps
module dspm_host_model (
    input  wire logic i_dout
);
    logic sclk   = 1'b1;
    logic sync_n = 1'b1;
    logic din    = 1'b0;

    // ------------------------------------------------------------
    // Frame transfer
    // ------------------------------------------------------------
    // One bit: data set, readback taken, then falling and rising edge
    task automatic bit_xfer(input logic b, output logic r);
        din = b;
        #62.5;
        r = i_dout;
        sclk = 1'b0;
        #62.5;
        sclk = 1'b1;
    endtask

    task automatic end_frame();
        #62.5;
        sync_n = 1'b1;
        // Released data line: no pull, so never show the last bit
        din = ~din;
    endtask

    // Clock stands high between frames; count may be cut short
    task automatic send(input logic [23:0] w, input int n,
                        output logic [23:0] rd);
        int   i;
        logic r;
        rd = 24'h000000;
        sync_n = 1'b0;
        for (i = 0; i < n; i++)
        begin
            bit_xfer(w[23-i], r);
            rd[23-i] = r;
        end
        end_frame();
    endtask

    // Byte host: three bursts of eight edges, frame sync low throughout
    task automatic send_bytes(input logic [23:0] w);
        int   i;
        int   j;
        logic r;
        sync_n = 1'b0;
        for (j = 0; j < 3; j++)
        begin
            for (i = 0; i < 8; i++)
                bit_xfer(w[23 - 8 * j - i], r);
            #200;
        end
        end_frame();
    endtask
endmodule

// *** verification/dac_serial_port_monitor_ctrl_bench.sv ***
// Self-checking bench of the serial port and monitor control block
`timescale 1ns/100ps
`include "dspm_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
 miscompares++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module dac_serial_port_monitor_ctrl_bench;
    logic        clk  = 1'b0;
    logic        rst_n = 1'b1;
    logic        cs_n = 1'b1;
    logic        wr_n = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic [11:0] pdat = 12'h000;
    logic        ld_n = 1'b1;
    logic        dout, dout_oe_n, busy, cal, rlvl, iref, men, moe_n, lpul;
    logic [4:0]  msel;
    logic [23:0] rd;
    int          miscompares = 0;
    int          cmp_count = 0;

    dspm_host_model hm (
        .i_dout (dout)
    );

    dspm_ctrl #(.POR_CYC(20)) dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .i_sclk(hm.sclk), .i_sync_n(hm.sync_n), .i_din(hm.din),
        .o_dout(dout), .o_dout_oe_n(dout_oe_n),
        .i_par_cs_n(cs_n), .i_par_wr_n(wr_n), .i_channel_addr(addr),
        .i_par_data(pdat), .i_load_strobe_n(ld_n),
        .o_init_busy(busy), .o_cal_load(cal), .o_ref_level_sel(rlvl),
        .o_internal_ref_sel(iref), .o_monitor_en(men),
        .o_monitor_out_sel(msel), .o_monitor_out_oe_n(moe_n),
        .o_load_pulse(lpul)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [23:0] wd(input logic [5:0] a,
                                       input logic [11:0] d);
        return {4'h0, a, 2'h0, d};
    endfunction

    // Crossing needs a few system cycles after each word
    task automatic swr(input logic [5:0] a, input logic [11:0] d);
        hm.send(wd(a, d), 24, rd);
        tick(8);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Bounded wait for the power-on interval to end
    task automatic wait_init();
        int k;
        for (k = 0; k < 100 && busy !== 1'b0; k++)
            tick(1);
        if (busy !== 1'b0)
        begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic t_reset();
        rst_n <= 1'b0;
        tick(1);
        #1;
        `CHK("mon_oe_n", 1'b1, moe_n)
        tick(11);
        rst_n <= 1'b1;
        tick(2);
        `CHK("init_busy", 1'b1, busy)
        `CHK("cal_load", 1'b1, cal)
        `CHK("int_ref", 1'b0, iref)
        `CHK("mon_en", 1'b0, men)
        wait_init();
    endtask

    // Mid-run reset: control state returns to power-up values
    task automatic t_rerst();
        rst_n <= 1'b0;
        tick(2);
        #1;
        `CHK("mon_oe_n", 1'b1, moe_n)
        `CHK("int_ref", 1'b0, iref)
        `CHK("init_busy", 1'b1, busy)
        tick(1);
        rst_n <= 1'b1;
        wait_init();
        `CHK("mon_en", 1'b0, men)
    endtask

    task automatic t_ref();
        swr({1'b0, `DSPM_CTRL_ADDR}, 12'h500);
        `CHK("ref_lvl", 1'b1, rlvl)
        `CHK("int_ref", 1'b1, iref)
        hm.send(24'h800000, 24, rd);
        tick(8);
        `CHK("readback", 12'h500, rd[23:12])
        `CHK("dout_oe_n", 1'b1, dout_oe_n)
    endtask

    task automatic t_partial();
        hm.send(wd({1'b0, `DSPM_CTRL_ADDR}, 12'h000), 16, rd);
        tick(8);
        `CHK("int_ref", 1'b1, iref)
    endtask

    task automatic t_bytes();
        hm.send_bytes(wd({1'b0, `DSPM_CTRL_ADDR}, 12'h400));
        tick(8);
        `CHK("ref_lvl", 1'b1, rlvl)
        `CHK("int_ref", 1'b0, iref)
    endtask

    task automatic t_mon();
        logic [5:0] c;
        logic [5:0] codes [3] = '{6'h00, 6'h11, 6'h1F};
        int         i;
        swr(`DSPM_MON_CMD, 12'h005);
        `CHK("mon_oe_n", 1'b1, moe_n)
        swr({1'b0, `DSPM_CTRL_ADDR}, 12'h080);
        `CHK("mon_en", 1'b1, men)
        `CHK("ref_lvl", 1'b0, rlvl)
        for (i = 0; i < 3; i++)
        begin
            c = codes[i];
            swr(`DSPM_MON_CMD, {6'h00, c});
            `CHK("mon_sel", c[4:0], msel)
            `CHK("mon_oe_n", 1'b0, moe_n)
        end
        swr(`DSPM_MON_CMD, 12'h020);
        `CHK("mon_oe_n", 1'b1, moe_n)
        swr(`DSPM_MON_CMD, {6'h00, `DSPM_MON_OFF});
        `CHK("mon_oe_n", 1'b1, moe_n)
    endtask

    task automatic t_par();
        int k;
        int n;
        n = 0;
        addr <= `DSPM_CTRL_ADDR;
        pdat <= 12'h000;
        cs_n <= 1'b0;
        tick(1);
        wr_n <= 1'b0;
        tick(3);
        wr_n <= 1'b1;
        tick(3);
        cs_n <= 1'b1;
        tick(6);
        `CHK("int_ref", 1'b0, iref)
        ld_n <= 1'b0;
        for (k = 0; k < 10; k++)
        begin
            tick(1);
            #1;
            n += (lpul === 1'b1);
        end
        ld_n <= 1'b1;
        `CHK("load_pulses", 1, n)
    endtask

    initial
    begin
        t_reset();
        t_ref();
        t_partial();
        t_bytes();
        t_mon();
        t_rerst();
        t_par();
        summarize();
    end
endmodule
